//--- burst_order.sv
// burst column offset generator: beat index plus start to column offset.
// assumes a mode configuration that is stable while a burst runs.
module burst_order
	import ddr_cmd_pkg::*;
(
	// burst setup
	input  wire logic [2:0] start_col,
	input  wire logic [2:0] beat,
	input  wire logic [3:0] burst_len,
	input  wire logic       interleave,
	// result
	output logic [2:0]      col_offset
);
	logic [2:0] mask;
	logic [2:0] seq;

	always_comb begin
		mask = 3'(burst_len - 4'h1);
		seq = 3'(start_col + beat);
		if (interleave) begin
			col_offset = (start_col & ~mask) | ((start_col ^ beat) & mask);
		end else begin
			col_offset = (start_col & ~mask) | (seq & mask);
		end
	end
endmodule

//--- ddr_cmd_front.sv
// ddr sdram command front end: decodes mode, extended mode and activate
// commands, holds both mode registers, tracks open banks and burst order.
// assumes command pins come from a controller off this clock domain.
//
// Contract
// - dll enable is extended write with a0 low, ba0 high, rest low.
// - dll reset is mode write with a8 high, ba0 low.
// - each dll enable resets dll; 200 cycles wait follows it too.
// - extended write: cs, ras, cas, we low, ba0 high; store a0-a12, ba1.
// - extended a0 disables dll, a1 selects half drive; others low.
// - mode write: cs, ras, cas, we, ba0 low; store a0-a12.
// - fields: burst length 0-2, type 3, latency 4-6, test 7, dll reset 8.
// - burst lengths 2, 4 or 8 supported.
// - sequential order counts up from start and wraps in the burst block.
// - interleaved order is start xor beat count.
// - activate: cs, ras low, cas, we high; two bank bits pick bank.
// - chip select high ignores new commands, ongoing work continues.
module ddr_cmd_front
	import ddr_cmd_pkg::*;
(
	// clock and reset
	input  wire logic                     sys_clk,
	input  wire logic                     sys_rst,
	// command pins from the controller
	input  wire logic                     cke,
	input  wire ddr_cmd_pkg::cmd_pins_type cmd_pins,
	// burst order query
	input  wire logic [2:0]               start_col,
	input  wire logic [2:0]               beat,
	output logic [2:0]                    col_offset,
	// configuration seen by the core
	output ddr_cmd_pkg::mode_cfg_type     mode_cfg,
	output logic [ADDR_W-1:0]             mode_reg,
	output logic [ADDR_W:0]               ext_mode_reg,
	// status
	output logic [NUM_BANKS-1:0]          bank_open,
	output logic [ADDR_W-1:0]             open_row [NUM_BANKS],
	output logic                          dll_locked,
	output logic                          mrd_busy,
	output logic                          mode_valid,
	output logic                          cmd_error
);
	import ddr_cmd_pkg::*;

	// two-flop sync of the pin inputs
	cmd_pins_type pins_s1_q;
	cmd_pins_type pins_q;
	logic         cke_s1_q;
	logic         cke_q;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			pins_s1_q <= '1;
			pins_q <= '1;
			cke_s1_q <= 1'b0;
			cke_q <= 1'b0;
		end else begin
			pins_s1_q <= cmd_pins;
			pins_q <= pins_s1_q;
			cke_s1_q <= cke;
			cke_q <= cke_s1_q;
		end
	end

	function automatic cmd_kind_type decode(input cmd_pins_type p,
			input logic ck);
		cmd_kind_type k;
		k = CMD_NONE;
		if (!ck || p.cs_n) begin
			k = CMD_NONE;
		end else if (!p.ras_n && !p.cas_n && !p.we_n && p.ba[0]) begin
			k = CMD_EMRS;
		end else if (!p.ras_n && !p.cas_n && !p.we_n) begin
			k = CMD_MRS;
		end else if (!p.ras_n && p.cas_n && p.we_n) begin
			k = CMD_ACT;
		end
		return k;
	endfunction

	function automatic logic [3:0] bl_decode(input logic [2:0] c);
		logic [3:0] r;
		r = 4'h0;
		if (c == BL_CODE_2) begin
			r = 4'h2;
		end else if (c == BL_CODE_4) begin
			r = 4'h4;
		end else if (c == BL_CODE_8) begin
			r = 4'h8;
		end
		return r;
	endfunction

	// precharge: ras, we low, cas high; a10 selects all banks
	function automatic logic is_pre(input cmd_pins_type p, input logic ck);
		return ck && !p.cs_n && !p.ras_n && p.cas_n && !p.we_n;
	endfunction

	cmd_kind_type kind;
	logic         pre;
	assign kind = decode(pins_q, cke_q);
	assign pre = is_pre(pins_q, cke_q);

	// mode register state
	logic [ADDR_W-1:0] mr_q, mr_d;
	logic [ADDR_W:0]   emr_q, emr_d;
	logic              mr_wr_q, mr_wr_d;
	logic              emr_wr_q, emr_wr_d;
	logic [1:0]        mrd_q, mrd_d;
	logic [7:0]        lock_q, lock_d;
	logic              dll_lk_q, dll_lk_d;
	logic              err_q, err_d;
	logic              mrd_busy_q, mrd_busy_d;
	logic              mode_ok_q, mode_ok_d;
	mode_cfg_type      cfg_q, cfg_d;
	logic [NUM_BANKS-1:0] open_q, open_d;
	logic [ADDR_W-1:0] row_q [NUM_BANKS];
	logic [ADDR_W-1:0] row_d [NUM_BANKS];

	always_comb begin
		mr_d = mr_q;
		emr_d = emr_q;
		mr_wr_d = mr_wr_q;
		emr_wr_d = emr_wr_q;
		mrd_d = (mrd_q != 2'h0) ? mrd_q - 2'h1 : 2'h0;
		lock_d = (lock_q != 8'h00) ? lock_q - 8'h01 : 8'h00;
		dll_lk_d = dll_lk_q;
		err_d = 1'b0;
		open_d = open_q;
		row_d = row_q;
		if (kind == CMD_EMRS || kind == CMD_MRS) begin
			if (open_q != '0) begin
				err_d = 1'b1;
			end
			if (mrd_q != 2'h0 || lock_q != 8'h00) begin
				err_d = 1'b1;
			end
			mrd_d = MRD_CNT;
		end
		if (kind == CMD_EMRS) begin
			emr_d = {pins_q.ba[1], pins_q.addr};
			emr_wr_d = 1'b1;
			if (!pins_q.addr[EMR_DLLDIS_BIT]) begin
				lock_d = DLL_LOCK_CNT;
				dll_lk_d = 1'b0;
			end else begin
				dll_lk_d = 1'b0;
			end
		end
		if (kind == CMD_MRS) begin
			mr_d = pins_q.addr;
			mr_wr_d = 1'b1;
			if (!emr_wr_q) begin
				err_d = 1'b1;
			end
			if (pins_q.addr[MR_DLLRST_BIT]) begin
				lock_d = DLL_LOCK_CNT;
				dll_lk_d = 1'b0;
			end
		end
		// a reset or enable landing on the last count restarts the wait
		if (lock_q == 8'h01 && lock_d == 8'h00 &&
				!emr_d[EMR_DLLDIS_BIT]) begin
			dll_lk_d = 1'b1;
		end
		if (kind == CMD_ACT) begin
			if (open_q[pins_q.ba]) begin
				err_d = 1'b1;
			end
			open_d[pins_q.ba] = 1'b1;
			row_d[pins_q.ba] = pins_q.addr;
		end
		if (pre) begin
			if (pins_q.addr[10]) begin
				open_d = '0;
			end else begin
				open_d[pins_q.ba] = 1'b0;
			end
		end
		cfg_d.dll_enabled = emr_d[EMR_DLLDIS_BIT] == 1'b0 && emr_wr_d;
		cfg_d.half_drive = emr_d[EMR_DRIVE_BIT];
		cfg_d.burst_len = bl_decode(mr_d[MR_BL_LSB +: 3]);
		cfg_d.interleave = mr_d[MR_BT_BIT];
		cfg_d.cas_code = mr_d[MR_CL_LSB +: 3];
		cfg_d.cas_valid = (mr_d[MR_CL_LSB +: 3] == CL_CODE_2) ||
			(mr_d[MR_CL_LSB +: 3] == CL_CODE_25) ||
			(mr_d[MR_CL_LSB +: 3] == CL_CODE_3);
		cfg_d.test_mode = mr_d[MR_TM_BIT];
		mrd_busy_d = (mrd_d != 2'h0);
		mode_ok_d = mr_wr_d && emr_wr_d;
	end

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			mr_q <= MR_RESET;
			emr_q <= EMR_RESET;
			mr_wr_q <= 1'b0;
			emr_wr_q <= 1'b0;
			mrd_q <= 2'h0;
			lock_q <= 8'h00;
			dll_lk_q <= 1'b0;
			err_q <= 1'b0;
			mrd_busy_q <= 1'b0;
			mode_ok_q <= 1'b0;
			cfg_q <= '0;
			open_q <= '0;
			for (int i = 0; i < NUM_BANKS; i++) begin
				row_q[i] <= '0;
			end
		end else begin
			mr_q <= mr_d;
			emr_q <= emr_d;
			mr_wr_q <= mr_wr_d;
			emr_wr_q <= emr_wr_d;
			mrd_q <= mrd_d;
			lock_q <= lock_d;
			dll_lk_q <= dll_lk_d;
			err_q <= err_d;
			mrd_busy_q <= mrd_busy_d;
			mode_ok_q <= mode_ok_d;
			cfg_q <= cfg_d;
			open_q <= open_d;
			row_q <= row_d;
		end
	end

	// burst order output registered
	logic [2:0] off_c;
	logic [2:0] off_q;

	burst_order burst_order_inst (
		.start_col  (start_col),
		.beat       (beat),
		.burst_len  (cfg_q.burst_len),
		.interleave (cfg_q.interleave),
		.col_offset (off_c)
	);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			off_q <= 3'h0;
		end else begin
			off_q <= off_c;
		end
	end

	assign col_offset = off_q;
	assign mode_cfg = cfg_q;
	assign mode_reg = mr_q;
	assign ext_mode_reg = emr_q;
	assign bank_open = open_q;
	assign open_row = row_q;
	assign dll_locked = dll_lk_q;
	assign mrd_busy = mrd_busy_q;
	assign mode_valid = mode_ok_q;
	assign cmd_error = err_q;

	a_emrs_store: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		kind == CMD_EMRS |=> emr_q == {$past(pins_q.ba[1]),
		$past(pins_q.addr)}) else $error("emrs not stored");
	a_mrs_store: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		kind == CMD_MRS |=> mr_q == $past(pins_q.addr))
		else $error("mrs not stored");
	a_mrd_window: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		kind == CMD_MRS |=> mrd_busy ##1 mrd_busy ##1 !mrd_busy)
		else $error("mode write window wrong");
	a_dll_lock_wait: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(kind == CMD_MRS && pins_q.addr[MR_DLLRST_BIT]) |=>
		!dll_locked [*8]) else $error("dll locked too early");
	a_enable_lock: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(kind == CMD_EMRS && !pins_q.addr[0] && lock_q == 8'h00) |=>
		lock_q == DLL_LOCK_CNT) else $error("dll enable no wait");
	a_cs_ignore: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		pins_q.cs_n |=> $stable(mr_q) && $stable(emr_q))
		else $error("command taken while deselected");
	a_act_open: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(kind == CMD_ACT && !pre) |=> bank_open[$past(pins_q.ba)])
		else $error("activate did not open bank");
	a_reopen_flag: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(kind == CMD_ACT && open_q[pins_q.ba]) |=> cmd_error)
		else $error("reactivate not flagged");
	a_busy_flag: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(kind == CMD_MRS && open_q != '0) |=> cmd_error)
		else $error("mode write with open bank not flagged");
	a_interleave: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(cfg_q.interleave && cfg_q.burst_len == 4'h8) |=>
		col_offset == ($past(start_col) ^ $past(beat)))
		else $error("interleave order wrong");
	a_drive_store: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		kind == CMD_EMRS |=>
		mode_cfg.half_drive == $past(pins_q.addr[EMR_DRIVE_BIT]))
		else $error("drive strength not stored");
	a_burst_len: assert property (
		@(posedge sys_clk) disable iff (sys_rst)
		(kind == CMD_MRS &&
		pins_q.addr[MR_BL_LSB +: 3] == BL_CODE_8) |=>
		mode_cfg.burst_len == 4'h8)
		else $error("burst length not eight");
endmodule

//--- ddr_cmd_pkg.sv
// package for the ddr command front end: command pins, register fields,
// burst and latency codes, timing counts.
// assumes a 250 MHz sys_clk sampling the command pins.
package ddr_cmd_pkg;

	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;

	// mode register field positions
	localparam int MR_BL_LSB = 0;
	localparam int MR_BT_BIT = 3;
	localparam int MR_CL_LSB = 4;
	localparam int MR_TM_BIT = 7;
	localparam int MR_DLLRST_BIT = 8;
	// extended mode register field positions
	localparam int EMR_DLLDIS_BIT = 0;
	localparam int EMR_DRIVE_BIT = 1;

	localparam logic [12:0] MR_RESET = 13'h0000;
	localparam logic [13:0] EMR_RESET = 14'h0000;

	// burst length codes
	localparam logic [2:0] BL_CODE_2 = 3'h1;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	// cas latency codes
	localparam logic [2:0] CL_CODE_2 = 3'h2;
	localparam logic [2:0] CL_CODE_25 = 3'h6;
	localparam logic [2:0] CL_CODE_3 = 3'h3;

	// timing
	localparam int CLK_MHZ = 250;
	localparam int MRD_CYCLES = 2;
	localparam int DLL_LOCK_CYCLES = 200;
	localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CYCLES);
	localparam logic [1:0] MRD_CNT = 2'(MRD_CYCLES);

	typedef struct packed {
		logic                cs_n;
		logic                ras_n;
		logic                cas_n;
		logic                we_n;
		logic [BANK_W-1:0]   ba;
		logic [ADDR_W-1:0]   addr;
	} cmd_pins_type;

	typedef struct packed {
		logic       dll_enabled;
		logic       half_drive;
		logic [3:0] burst_len;
		logic       interleave;
		logic [2:0] cas_code;
		logic       cas_valid;
		logic       test_mode;
	} mode_cfg_type;

	typedef enum logic [1:0] {
		CMD_NONE,
		CMD_MRS,
		CMD_EMRS,
		CMD_ACT
	} cmd_kind_type;

endpackage

//--- ddr_ctl_model.sv
// controller model: drives clock enable and command pins of the front end.
// assumes tasks are called by the bench at sys_clk rising edges.
module ddr_ctl_model
	import ddr_cmd_pkg::*;
(
	// clock
	input  wire logic                 sys_clk,
	// pins toward the device
	output ddr_cmd_pkg::cmd_pins_type cmd_pins,
	output logic                      cke
);
	initial begin
		cke = 1'b0;
		cmd_pins = '1;
	end
	// a deselected bus shows the inverse, so a stale command never lingers
	task automatic send(input logic [3:0] c, input logic [1:0] ba,
			input logic [12:0] a);
		cmd_pins <= {c, ba, a};
		@(posedge sys_clk);
		cmd_pins <= {1'b1, ~c[2:0], ~ba, ~a};
	endtask
	// the stable-clock wait is shortened; the front end has no timer on it
	task automatic power_up(input int n);
		repeat (n) @(posedge sys_clk);
		cke <= 1'b1;
	endtask
endmodule

//--- ddr_sdram_init_mode_activate_bench.sv
// self-checking bench for the ddr command front end.
// assumes the controller model drives the pins; bench drives burst queries.
module ddr_sdram_init_mode_activate_bench
	import ddr_cmd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic         sys_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         cke;
	cmd_pins_type cmd_pins;
	logic [2:0]   start_col = 3'h0;
	logic [2:0]   beat = 3'h0;
	logic [2:0]   col_offset;
	mode_cfg_type mode_cfg;
	logic [12:0]  mode_reg;
	logic [13:0]  ext_mode_reg;
	logic [3:0]   bank_open;
	logic [12:0]  open_row [4];
	logic         dll_locked;
	logic         mrd_busy;
	logic         mode_valid;
	logic         cmd_error;
	int           fail_count = 0;
	int           total_checks = 0;
	int           seed = 56295;
	logic [12:0]  a;
	logic [3:0]   bl;

	always #2 sys_clk = ~sys_clk;

	ddr_ctl_model ddr_ctl_model_inst (
		.sys_clk  (sys_clk),
		.cmd_pins (cmd_pins),
		.cke      (cke)
	);
	ddr_cmd_front ddr_cmd_front_inst (
		.sys_clk      (sys_clk),
		.sys_rst      (sys_rst),
		.cke          (cke),
		.cmd_pins     (cmd_pins),
		.start_col    (start_col),
		.beat         (beat),
		.col_offset   (col_offset),
		.mode_cfg     (mode_cfg),
		.mode_reg     (mode_reg),
		.ext_mode_reg (ext_mode_reg),
		.bank_open    (bank_open),
		.open_row     (open_row),
		.dll_locked   (dll_locked),
		.mrd_busy     (mrd_busy),
		.mode_valid   (mode_valid),
		.cmd_error    (cmd_error)
	);

	task automatic chk(input logic [13:0] g, input logic [13:0] e);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	// five edges cover the two-flop sync, the decode register and tMRD
	task automatic issue(input logic [3:0] c, input logic [1:0] ba,
			input logic [12:0] ad);
		ddr_ctl_model_inst.send(c, ba, ad);
		tick(5);
	endtask
	task automatic wait_lock;
		int i;
		for (i = 0; i < 300 && dll_locked !== 1'b1; i++)
			tick(1);
		if (dll_locked !== 1'b1) begin
			fail_count++;
			close_out;
		end
	endtask
	// error is a one-cycle pulse: look at falling edges, where it is settled
	task automatic expect_err(input logic [3:0] c, input logic [1:0] ba,
			input logic [12:0] ad);
		int i;
		logic seen;
		seen = 1'b0;
		ddr_ctl_model_inst.send(c, ba, ad);
		for (i = 0; i < 8 && !seen; i++) begin
			@(negedge sys_clk);
			seen = (cmd_error === 1'b1);
		end
		chk(14'(seen), 14'h1);
		tick(3);
	endtask
	function automatic logic [3:0] exp_bl(input logic [2:0] c);
		return (c == 3'h1) ? 4'h2 : (c == 3'h2) ? 4'h4 :
			(c == 3'h3) ? 4'h8 : 4'h0;
	endfunction
	// wrap inside the burst-sized block, or start xor beat count
	function automatic logic [2:0] exp_col(input int s, input int b,
			input int n, input logic il);
		int lo;
		lo = s % n;
		if (il)
			return 3'(s ^ b);
		return 3'(s - lo + (lo + b) % n);
	endfunction

	initial begin
		int k;
		int s;
		int b;
		int n;
		int e;
		tick(16);
		sys_rst <= 1'b0;
		tick(1);
		chk(14'(mode_reg), 14'h0);
		chk(14'(bank_open), 14'h0);
		ddr_ctl_model_inst.power_up(20);
		issue(4'h2, 2'h0, 13'h0400);
		a = {11'h0, 1'($random(seed)), 1'b0};
		issue(4'h0, 2'h1, a);
		chk(ext_mode_reg, {1'b0, a});
		chk(14'(mode_cfg.half_drive), 14'(a[1]));
		chk(14'(mode_cfg.dll_enabled), 14'h1);
		wait_lock;
		issue(4'h0, 2'h0, 13'h0100);
		chk(14'(dll_locked), 14'h0);
		wait_lock;
		issue(4'h2, 2'h0, 13'h0400);
		issue(4'h1, 2'h0, 13'h0);
		issue(4'h1, 2'h0, 13'h0);
		$display("init sequence done");
		ddr_ctl_model_inst.send(4'h0, 2'h0, 13'h0022);
		repeat (2) @(negedge sys_clk);
		chk(14'(mrd_busy), 14'h0);
		n = 0;
		e = 0;
		repeat (4) begin
			@(negedge sys_clk);
			n = n + int'(mrd_busy);
			e = e + int'(cmd_error);
		end
		chk(14'(n), 14'(MRD_CYCLES));
		chk(14'(e), 14'h0);
		chk(14'(mode_cfg.test_mode), 14'h0);
		tick(1);
		for (k = 0; k < 16; k++) begin
			a = {6'h0, 3'(k), k[3], 3'(k)};
			issue(4'h0, 2'h0, a);
			chk(14'(mode_valid), 14'h1);
			chk({1'b0, mode_reg}, {1'b0, a});
			chk(14'(mode_cfg.burst_len), 14'(exp_bl(a[2:0])));
			chk(14'(mode_cfg.interleave), 14'(a[3]));
			chk(14'(mode_cfg.cas_code), 14'(a[6:4]));
			chk(14'(mode_cfg.cas_valid),
				14'(a[6:4] inside {3'h2, 3'h3, 3'h6}));
			bl = exp_bl(a[2:0]);
			for (s = 0; s < 8 && bl != 4'h0; s++)
				for (b = 0; b < int'(bl); b++) begin
					start_col <= 3'(s);
					beat <= 3'(b);
					tick(2);
					chk(14'(col_offset),
						14'(exp_col(s, b, int'(bl), a[3])));
				end
		end
		$display("mode and burst test done");
		issue(4'h8, 2'h0, 13'h0033);
		chk({1'b0, mode_reg}, {1'b0, a});
		for (k = 0; k < 4; k++) begin
			a = 13'($random(seed));
			issue(4'h3, 2'(k), a);
			chk(14'(bank_open[k]), 14'h1);
			chk(14'(open_row[k]), {1'b0, a});
		end
		expect_err(4'h3, 2'h2, 13'h0000);
		expect_err(4'h0, 2'h0, 13'h0011);
		issue(4'h2, 2'h0, 13'h0400);
		chk(14'(bank_open), 14'h0);
		$display("activate test done");
		close_out;
	end
endmodule
